/* rtl/acs_regs.sv */
`timescale 1ns/1ps
module acs_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Converter word clock from the record path
  input wire logic wordClk,
  // AXI4-Lite write address
  input wire logic [acs_pkg::ACS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [acs_pkg::ACS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Record path controls
  output acs_pkg::acs_ctrl_t ctrl
);
  import acs_pkg::*;

  logic [7:0] setup_q;
  logic [7:0] trim_q;
  logic [6:0] volL_q;
  logic [6:0] volR_q;
  logic [7:0] phase_q;
  logic [6:0] appL_q;
  logic [6:0] appR_q;

  // Byte address to register index; misaligned gives no match
  // Upper address bits must be zero as well, so the map never aliases
  function automatic logic [8:0] regIndex(
    input logic [ACS_ADDR_W-1:0] addr
  );
    logic bad;
    bad = addr[1:0] != 2'b00 || addr[ACS_ADDR_W-1:10] != '0;
    regIndex = {bad, addr[9:2]};
  endfunction

  // One decode per register keeps the read and write maps in step
  function automatic logic isReg(
    input logic [8:0] idx,
    input logic [7:0] regIdx
  );
    isReg = idx == {1'b0, regIdx};
  endfunction

  function automatic logic isMapped(input logic [8:0] idx);
    isMapped = isReg(idx, ACS_IDX_SETUP) ||
      isReg(idx, ACS_IDX_TRIM) ||
      isReg(idx, ACS_IDX_VOL_L) ||
      isReg(idx, ACS_IDX_VOL_R) ||
      isReg(idx, ACS_IDX_PHASE) ||
      isReg(idx, ACS_IDX_STATUS);
  endfunction

  // One half-decibel step of a signed volume toward its target
  function automatic logic [6:0] stepToward(
    input logic [6:0] cur,
    input logic [6:0] tgt
  );
    if ($signed(cur) < $signed(tgt)) begin
      stepToward = cur + 7'h01;
    end else if ($signed(cur) > $signed(tgt)) begin
      stepToward = cur - 7'h01;
    end else begin
      stepToward = cur;
    end
  endfunction

  // ---------------- Write channel ----------------
  logic awHeld_q;
  logic wHeld_q;
  logic [ACS_ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [8:0] wIdx;

  // Address and data are taken in either order and held until used
  assign awready = !awHeld_q && !bvalid;
  assign wready = !wHeld_q && !bvalid;
  assign doWrite = awHeld_q && wHeld_q && !bvalid;
  assign wIdx = regIndex(awAddr_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else if (awvalid && awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (wvalid && wready) begin
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  // A response not yet taken keeps both write readies low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= ACS_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= isMapped(wIdx) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Registers are eight bits wide, so only lane 0 carries a write
  // The status word is read-only: a write there answers OKAY, no effect
  logic regWr;
  assign regWr = doWrite && wStrb_q[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      setup_q <= ACS_RST_SETUP;
    end else if (regWr && isReg(wIdx, ACS_IDX_SETUP)) begin
      setup_q <= wData_q[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trim_q <= ACS_RST_TRIM;
    end else if (regWr && isReg(wIdx, ACS_IDX_TRIM)) begin
      trim_q <= wData_q[7:0];
    end
  end

  // Bit 7 is reserved: never stored, always read as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volL_q <= ACS_RST_VOL;
    end else if (regWr && isReg(wIdx, ACS_IDX_VOL_L)) begin
      volL_q <= wData_q[6:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volR_q <= ACS_RST_VOL;
    end else if (regWr && isReg(wIdx, ACS_IDX_VOL_R)) begin
      volR_q <= wData_q[6:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= ACS_RST_PHASE;
    end else if (regWr && isReg(wIdx, ACS_IDX_PHASE)) begin
      phase_q <= wData_q[7:0];
    end
  end

  // ---------------- Read channel ----------------
  logic [8:0] rIdx;
  logic [31:0] rWord;
  logic busy;

  assign rIdx = regIndex(araddr);
  assign arready = !rvalid;
  assign busy = (appL_q != volL_q) || (appR_q != volR_q);

  always_comb begin
    rWord = '0;
    case (rIdx)
      {1'b0, ACS_IDX_SETUP}: rWord[7:0] = setup_q;
      {1'b0, ACS_IDX_TRIM}: rWord[7:0] = trim_q;
      {1'b0, ACS_IDX_VOL_L}: rWord[6:0] = volL_q;
      {1'b0, ACS_IDX_VOL_R}: rWord[6:0] = volR_q;
      {1'b0, ACS_IDX_PHASE}: rWord[7:0] = phase_q;
      {1'b0, ACS_IDX_STATUS}: begin
        rWord[ACS_B_ST_VOL_L +: 7] = appL_q;
        rWord[ACS_B_ST_VOL_R +: 7] = appR_q;
        rWord[ACS_B_ST_BUSY] = busy;
      end
      default: rWord = '0;
    endcase
  end

  // Read data is captured with the address, so a later write cannot tear it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ACS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rWord;
      rresp <= isMapped(rIdx) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- Word clock ticks ----------------
  // The word clock is foreign to this domain: two flops, then edge
  // Ticks land about two clocks after the pin edge
  logic [1:0] wcSync_q;
  logic wcLast_q;
  logic wordTick;
  logic halfTick_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wcSync_q <= 2'b00;
      wcLast_q <= 1'b0;
    end else begin
      wcSync_q <= {wcSync_q[0], wordClk};
      wcLast_q <= wcSync_q[1];
    end
  end

  assign wordTick = wcSync_q[1] && !wcLast_q;

  // Halving phase runs free: mode 01 may wait one extra tick at first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halfTick_q <= 1'b0;
    end else if (wordTick) begin
      halfTick_q <= !halfTick_q;
    end
  end

  // ---------------- Volume soft stepping ----------------
  logic [1:0] stepMode;
  logic stepNow;
  logic jumpNow;

  assign stepMode = setup_q[ACS_B_STEP_HI:ACS_B_STEP_LO];

  // Reserved code 11 behaves as stepping disabled, so it cannot stall
  always_comb begin
    stepNow = 1'b0;
    jumpNow = 1'b0;
    case (stepMode)
      ACS_STEP_EVERY: stepNow = wordTick;
      ACS_STEP_TWO: stepNow = wordTick && halfTick_q;
      ACS_STEP_OFF: jumpNow = 1'b1;
      default: jumpNow = 1'b1;
    endcase
  end

  // A target written mid-walk simply redirects the walk
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      appL_q <= ACS_RST_VOL;
      appR_q <= ACS_RST_VOL;
    end else if (jumpNow) begin
      appL_q <= volL_q;
      appR_q <= volR_q;
    end else if (stepNow) begin
      appL_q <= stepToward(appL_q, volL_q);
      appR_q <= stepToward(appR_q, volR_q);
    end
  end

  // ---------------- Outputs ----------------
  logic [7:0] phaseMag;

  // Negative codes take their two's complement so 0x80 is the longest
  assign phaseMag = phase_q[7] ? 8'h00 - phase_q : phase_q;

  // The record path sees only flops: volumes one clock behind appL_q/appR_q, the rest one clock behind the bank
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl.leftPowerUp <= ACS_RST_SETUP[ACS_B_PWR_L];
      ctrl.rightPowerUp <= ACS_RST_SETUP[ACS_B_PWR_R];
      ctrl.dmicSource <= ACS_RST_SETUP[ACS_B_SRC_HI:ACS_B_SRC_LO];
      ctrl.leftUseDmic <= ACS_RST_SETUP[ACS_B_DMIC_L];
      ctrl.rightUseDmic <= ACS_RST_SETUP[ACS_B_DMIC_R];
      ctrl.leftMute <= ACS_RST_TRIM[ACS_B_MUTE_L];
      ctrl.rightMute <= ACS_RST_TRIM[ACS_B_MUTE_R];
      ctrl.leftTrim <= ACS_RST_TRIM[ACS_B_TRIM_L_HI:ACS_B_TRIM_L_LO];
      ctrl.rightTrim <= ACS_RST_TRIM[ACS_B_TRIM_R_HI:ACS_B_TRIM_R_LO];
      ctrl.leftVolume <= ACS_RST_VOL;
      ctrl.rightVolume <= ACS_RST_VOL;
      ctrl.delayLeft <= 1'b0;
      ctrl.delayRight <= 1'b0;
      ctrl.delayAmount <= ACS_RST_PHASE;
    end else begin
      ctrl.leftPowerUp <= setup_q[ACS_B_PWR_L];
      ctrl.rightPowerUp <= setup_q[ACS_B_PWR_R];
      ctrl.dmicSource <= setup_q[ACS_B_SRC_HI:ACS_B_SRC_LO];
      ctrl.leftUseDmic <= setup_q[ACS_B_DMIC_L];
      ctrl.rightUseDmic <= setup_q[ACS_B_DMIC_R];
      ctrl.leftMute <= trim_q[ACS_B_MUTE_L];
      ctrl.rightMute <= trim_q[ACS_B_MUTE_R];
      ctrl.leftTrim <= trim_q[ACS_B_TRIM_L_HI:ACS_B_TRIM_L_LO];
      ctrl.rightTrim <= trim_q[ACS_B_TRIM_R_HI:ACS_B_TRIM_R_LO];
      ctrl.leftVolume <= appL_q;
      ctrl.rightVolume <= appR_q;
      ctrl.delayLeft <= phase_q[7];
      ctrl.delayRight <= !phase_q[7] && phase_q != 8'h00;
      ctrl.delayAmount <= phaseMag;
    end
  end
endmodule

/* pkg/acs_pkg.sv */
package acs_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] ACS_IDX_SETUP = 8'h51;
  localparam logic [7:0] ACS_IDX_TRIM = 8'h52;
  localparam logic [7:0] ACS_IDX_VOL_L = 8'h53;
  localparam logic [7:0] ACS_IDX_VOL_R = 8'h54;
  localparam logic [7:0] ACS_IDX_PHASE = 8'h55;
  localparam logic [7:0] ACS_IDX_STATUS = 8'h60;
  localparam int ACS_ADDR_W = 12;

  // Reset values
  localparam logic [7:0] ACS_RST_SETUP = 8'h00;
  localparam logic [7:0] ACS_RST_TRIM = 8'h88;
  localparam logic [6:0] ACS_RST_VOL = 7'h00;
  localparam logic [7:0] ACS_RST_PHASE = 8'h00;

  // Setup register fields
  localparam int ACS_B_PWR_L = 7;
  localparam int ACS_B_PWR_R = 6;
  localparam int ACS_B_SRC_HI = 5;
  localparam int ACS_B_SRC_LO = 4;
  localparam int ACS_B_DMIC_L = 3;
  localparam int ACS_B_DMIC_R = 2;
  localparam int ACS_B_STEP_HI = 1;
  localparam int ACS_B_STEP_LO = 0;

  // Trim register fields
  localparam int ACS_B_MUTE_L = 7;
  localparam int ACS_B_TRIM_L_HI = 6;
  localparam int ACS_B_TRIM_L_LO = 4;
  localparam int ACS_B_MUTE_R = 3;
  localparam int ACS_B_TRIM_R_HI = 2;
  localparam int ACS_B_TRIM_R_LO = 0;

  // Status register fields
  localparam int ACS_B_ST_BUSY = 15;
  localparam int ACS_B_ST_VOL_R = 8;
  localparam int ACS_B_ST_VOL_L = 0;

  // Stepping rate codes
  localparam logic [1:0] ACS_STEP_EVERY = 2'b00;
  localparam logic [1:0] ACS_STEP_TWO = 2'b01;
  localparam logic [1:0] ACS_STEP_OFF = 2'b10;

  // Microphone source codes
  localparam logic [1:0] ACS_SRC_GPIO = 2'b00;
  localparam logic [1:0] ACS_SRC_BCLK = 2'b01;
  localparam logic [1:0] ACS_SRC_DIN = 2'b10;

  localparam logic [1:0] ACS_RESP_OKAY = 2'b00;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic leftPowerUp;
    logic rightPowerUp;
    logic [1:0] dmicSource;
    logic leftUseDmic;
    logic rightUseDmic;
    logic leftMute;
    logic rightMute;
    logic [2:0] leftTrim;
    logic [2:0] rightTrim;
    logic [6:0] leftVolume;
    logic [6:0] rightVolume;
    logic delayLeft;
    logic delayRight;
    logic [7:0] delayAmount;
  } acs_ctrl_t;
endpackage

/* verif/acs_regs_chk.sv */
`timescale 1ns/1ps
module acs_regs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Record path controls
  input wire acs_pkg::acs_ctrl_t ctrl
);
  import acs_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_no_delay: assert property (
    ctrl.delayAmount == 8'h00 |-> !ctrl.delayLeft && !ctrl.delayRight)
    else $error("delay without amount");
  a_delay_left: assert property (
    ctrl.delayLeft |-> !ctrl.delayRight && ctrl.delayAmount inside {[1:128]})
    else $error("left delay amount wrong");
  a_delay_right: assert property (
    ctrl.delayRight |-> ctrl.delayAmount inside {[1:127]})
    else $error("right delay amount wrong");
  // Setting fields move only one clock after a write answer rises
  a_ctrl_quiet: assert property (
    !$stable({ctrl.leftPowerUp, ctrl.rightPowerUp, ctrl.dmicSource,
      ctrl.leftUseDmic, ctrl.rightUseDmic, ctrl.leftMute, ctrl.rightMute,
      ctrl.leftTrim, ctrl.rightTrim}) |-> $past(bvalid) && !$past(bvalid, 2))
    else $error("control moved without write");
  c_write: cover property (bvalid && bready);
  c_resp_wait: cover property (bvalid && !bready);
  c_left: cover property (ctrl.delayLeft);
  c_right: cover property (ctrl.delayRight);
endmodule

/* verif/test_acs_regs.sv */
`timescale 1ns/1ps
module test_acs_regs;
  import acs_pkg::*;
  logic clock = 0, rst = 1, wordClk = 0;
  logic [ACS_ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] v;
  acs_ctrl_t ctrl;
  logic [31:0] want, seen;
  logic [3:0] strbSel = 4'hF;
  int bWait = 0;
  int miscompares = 0, numChecks = 0;
  logic [7:0] rstVal [5] = '{8'h00, 8'h88, 8'h00, 8'h00, 8'h00};
  logic [7:0] setupVal [3] = '{8'h80, 8'h5D, 8'h6A};
  logic [7:0] phaseVal [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
  always #2 clock = ~clock;
  acs_regs acs_regs_inst (.clock(clock), .rst(rst), .wordClk(wordClk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ctrl(ctrl));
  function automatic logic [11:0] ra(logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic chkWord(string what, logic [31:0] exp, logic [31:0] seen);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chkResp(string what, logic [1:0] exp, logic [1:0] seen);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Settled outputs are looked at mid-cycle; the next rising edge acts
  task automatic wr(logic [11:0] a, logic [7:0] d, logic [1:0] er);
    int n;
    logic awTake, wTake, done;
    logic [1:0] resp;
    n = 0;
    done = 0;
    resp = 2'bxx;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= strbSel;
    awvalid <= 1;
    wvalid <= 1;
    bready <= (bWait == 0);
    while (!done && n < 50) begin
      @(negedge clock);
      awTake = awvalid && awready;
      wTake = wvalid && wready;
      done = bvalid && bready;
      if (done) resp = bresp;
      @(posedge clock);
      n++;
      if (awTake) awvalid <= 0;
      if (wTake) wvalid <= 0;
      if (!done && n >= bWait && n < 50) bready <= 1;
    end
    bready <= 0;
    chkResp("bresp", er, resp);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    logic arTake, done;
    logic [31:0] data;
    logic [1:0] resp;
    n = 0;
    done = 0;
    data = 'x;
    resp = 2'bxx;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done && n < 50) begin
      @(negedge clock);
      arTake = arvalid && arready;
      done = rvalid && rready;
      if (done) data = rdata;
      if (done) resp = rresp;
      @(posedge clock);
      n++;
      if (arTake) arvalid <= 0;
    end
    rready <= 0;
    chkWord("rdata", ed, data);
    chkResp("rresp", er, resp);
  endtask
  // Slow word clock so the two-flop sync never misses an edge
  task automatic ticks(int k);
    repeat (k) begin
      repeat (4) @(posedge clock);
      wordClk <= 1;
      repeat (4) @(posedge clock);
      wordClk <= 0;
    end
    repeat (8) @(posedge clock);
  endtask
  task automatic stopTest;
    $display("Checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    stopTest();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      rd(ra(ACS_IDX_SETUP + 8'(i)), {24'h00_0000, rstVal[i]}, 2'b00);
    end
    chkWord("mutes", 32'h3, {30'h0, ctrl.leftMute, ctrl.rightMute});
    foreach (setupVal[i]) begin
      v = setupVal[i];
      wr(ra(ACS_IDX_SETUP), v, ACS_RESP_OKAY);
      rd(ra(ACS_IDX_SETUP), {24'h00_0000, v}, ACS_RESP_OKAY);
      seen = {26'h0, ctrl.leftPowerUp, ctrl.rightPowerUp, ctrl.dmicSource,
        ctrl.leftUseDmic, ctrl.rightUseDmic};
      chkWord("setup", {26'h0, v[7:2]}, seen);
    end
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h50 : 8'h7C;
      wr(ra(ACS_IDX_TRIM), v, ACS_RESP_OKAY);
      rd(ra(ACS_IDX_TRIM), {24'h00_0000, v}, ACS_RESP_OKAY);
      seen = {24'h0, ctrl.leftMute, ctrl.leftTrim, ctrl.rightMute,
        ctrl.rightTrim};
      chkWord("trim", {24'h0, v}, seen);
    end
    wr(ra(ACS_IDX_VOL_L), 8'h68, ACS_RESP_OKAY);
    rd(ra(ACS_IDX_VOL_L), 32'h0000_0068, ACS_RESP_OKAY);
    chkWord("volL", 32'h68, {25'h0, ctrl.leftVolume});
    wr(ra(ACS_IDX_SETUP), 8'hC0, ACS_RESP_OKAY);
    wr(ra(ACS_IDX_VOL_R), 8'h28, ACS_RESP_OKAY);
    ticks(5);
    chkWord("step1", 32'h5, {25'h0, ctrl.rightVolume});
    wr(ra(ACS_IDX_SETUP), 8'hC1, ACS_RESP_OKAY);
    ticks(6);
    chkWord("step2", 32'h8, {25'h0, ctrl.rightVolume});
    rd(ra(ACS_IDX_STATUS), 32'h0000_8868, ACS_RESP_OKAY);
    wr(ra(ACS_IDX_SETUP), 8'hC2, ACS_RESP_OKAY);
    repeat (3) @(posedge clock);
    chkWord("volR", 32'h28, {25'h0, ctrl.rightVolume});
    rd(ra(ACS_IDX_STATUS), 32'h0000_2868, ACS_RESP_OKAY);
    foreach (phaseVal[i]) begin
      v = phaseVal[i];
      wr(ra(ACS_IDX_PHASE), v, ACS_RESP_OKAY);
      repeat (3) @(posedge clock);
      want = {22'h0, v[7], v != 0 && !v[7], v[7] ? 8'(-v) : v};
      seen = {22'h0, ctrl.delayLeft, ctrl.delayRight, ctrl.delayAmount};
      chkWord("phase", want, seen);
    end
    // Lane 0 off and a slow response taker: OKAY, trim keeps its value
    strbSel = 4'hE;
    bWait = 4;
    wr(ra(ACS_IDX_TRIM), 8'h00, ACS_RESP_OKAY);
    strbSel = 4'hF;
    bWait = 0;
    rd(ra(ACS_IDX_TRIM), 32'h0000_0050, ACS_RESP_OKAY);
    wr(12'h200, 8'h55, ACS_RESP_SLVERR);
    rd(12'h200, 32'h0, ACS_RESP_SLVERR);
    rd(12'h146, 32'h0, ACS_RESP_SLVERR);
    stopTest();
  end
endmodule
bind acs_regs acs_regs_chk acs_regs_chk_inst (.clock(clock), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .ctrl(ctrl));
